//--- verilog/lcd_timing_pkg.sv
package lcd_timing_pkg;

    // clock rates
    localparam int CLK_HZ = 100_000_000;
    localparam int FAST_SRC_HZ = 2048;
    localparam int SLOW_SRC_HZ = 128;

    // special function register addresses
    localparam logic [7:0] ADDR_MAIN_CFG = 8'h95;
    localparam logic [7:0] ADDR_TIMING_CFG = 8'h96;
    localparam logic [7:0] ADDR_LADDER_CFG = 8'h9c;
    localparam logic [7:0] ADDR_REFRESH_CTRL = 8'hb1;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // main configuration fields
    localparam int MAIN_DRV_EN_BIT = 7;
    localparam int MAIN_FLASH_EN_BIT = 5;
    localparam int MAIN_CLK_SEL_BIT = 3;
    localparam int MAIN_MUX_LSB = 0;

    // ladder and refresh fields
    localparam int LADDER_SEL_BIT = 6;
    localparam int REFRESH_INV_BIT = 6;
    localparam int REFRESH_DONE_BIT = 1;
    localparam int REFRESH_HOLD_BIT = 0;

    // timing configuration fields
    localparam int TIMING_SRC_LSB = 6;
    localparam int TIMING_RATE_LSB = 4;
    localparam int TIMING_FD_LSB = 0;

    // blink source codes
    localparam logic [1:0] BLINK_SW_OFF = 2'h0;
    localparam logic [1:0] BLINK_SW_ON = 2'h1;
    localparam logic [1:0] BLINK_FIXED = 2'h2;
    localparam logic [1:0] BLINK_RATE = 2'h3;

    // multiplex codes, zero is reserved and served as four-way
    localparam logic [1:0] MUX_2X = 2'h1;
    localparam logic [1:0] MUX_3X = 2'h2;

    // blink half periods in 128 Hz ticks
    localparam int TICK_W = 9;
    localparam logic [TICK_W-1:0] BLINK_HALF_2HZ = 9'h020;
    localparam logic [TICK_W-1:0] BLINK_HALF_1HZ = 9'h040;

    // frame length in source ticks, fast source: unit times divider steps
    localparam logic [3:0] FAST_UNIT_EVEN = 4'h8;
    localparam logic [3:0] FAST_UNIT_3X = 4'h6;
    localparam logic [5:0] FD_ZERO_STEPS = 6'h20;

    // frame length on the slow source: unit times multiplier
    localparam logic [3:0] SLOW_UNIT_2X = 4'h2;
    localparam logic [3:0] SLOW_UNIT_3X = 4'h3;
    localparam logic [3:0] SLOW_UNIT_4X = 4'h4;
    localparam logic [3:0] SLOW_MULT_FD15 = 4'h1;
    localparam logic [3:0] SLOW_MULT_FD0 = 4'h2;
    localparam logic [3:0] SLOW_MULT_STD = 4'h4;
    localparam logic [3:0] SLOW_MULT_2X_FD1 = 4'h4;
    localparam logic [3:0] SLOW_MULT_2X_FD2 = 4'h6;
    localparam logic [3:0] SLOW_MULT_2X_REST = 4'h8;
    localparam logic [3:0] FD_ONE = 4'h1;
    localparam logic [3:0] FD_TWO = 4'h2;
    localparam logic [3:0] FD_MAX = 4'hf;

endpackage : lcd_timing_pkg

//--- verilog/lcd_timing_if.sv
interface lcd_timing_if;
    import lcd_timing_pkg::*;

    logic driver_en;
    logic clk_sel;
    logic [1:0] mux_sel;
    logic [3:0] frame_div;
    logic blink_hw_en;
    logic [TICK_W-1:0] blink_half;
    logic frame_start;
    logic blink_visible;

    modport ctrl (
        output driver_en, clk_sel, mux_sel, frame_div, blink_hw_en, blink_half,
        input frame_start, blink_visible
    );
    modport timebase (
        input driver_en, clk_sel, mux_sel, frame_div, blink_hw_en, blink_half,
        output frame_start, blink_visible
    );
endinterface : lcd_timing_if

//--- verilog/lcd_frame_timebase.sv
module lcd_frame_timebase
    import lcd_timing_pkg::*;
#(
    parameter int FAST_DIV = CLK_HZ / FAST_SRC_HZ,
    parameter int SLOW_DIV = CLK_HZ / SLOW_SRC_HZ
)(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // configuration in, frame and blink events out
    lcd_timing_if.timebase tb
);
    localparam int DIV_W = $clog2(SLOW_DIV + 1);

    if (FAST_DIV < 2 || SLOW_DIV <= FAST_DIV)
    begin : g_bad_div
        $error("prescaler divisors out of range");
    end

    typedef struct packed {
        logic [DIV_W-1:0] fast_cnt;
        logic [DIV_W-1:0] slow_cnt;
        logic [TICK_W-1:0] frame_cnt;
        logic [TICK_W-1:0] blink_cnt;
        logic blink_vis;
        logic frame_start;
    } tb_state_t;

    tb_state_t q, d;

    // frame length in source ticks for the chosen source, mux level and divider
    function automatic logic [TICK_W-1:0] frame_ticks(input logic slow, input logic [1:0] mux,
                                                      input logic [3:0] fd);
        logic [5:0] steps;
        logic [3:0] unit;
        logic [3:0] mult;
        steps = (fd == '0) ? FD_ZERO_STEPS : 6'(fd) + 6'h1;
        unit = (mux == MUX_3X) ? FAST_UNIT_3X : FAST_UNIT_EVEN;
        if (!slow)
        begin
            return TICK_W'(unit * steps);
        end
        unit = (mux == MUX_2X) ? SLOW_UNIT_2X : (mux == MUX_3X) ? SLOW_UNIT_3X : SLOW_UNIT_4X;
        if (fd == FD_MAX)
            mult = SLOW_MULT_FD15;
        else if (fd == '0)
            mult = SLOW_MULT_FD0;
        else if (mux != MUX_2X)
            mult = SLOW_MULT_STD;
        else if (fd == FD_ONE)
            mult = SLOW_MULT_2X_FD1;
        else if (fd == FD_TWO)
            mult = SLOW_MULT_2X_FD2;
        else
            mult = SLOW_MULT_2X_REST;
        return TICK_W'(unit * mult);
    endfunction : frame_ticks

    // prescalers, frame counter and blink phase
    always_comb
    begin
        logic fast_tick;
        logic slow_tick;
        logic src_tick;
        fast_tick = (q.fast_cnt == DIV_W'(FAST_DIV - 1));
        slow_tick = (q.slow_cnt == DIV_W'(SLOW_DIV - 1));
        src_tick = tb.clk_sel ? slow_tick : fast_tick; // see [RULE16]
        d = q;
        d.frame_start = 1'b0;
        d.fast_cnt = fast_tick ? '0 : q.fast_cnt + 1'b1;
        d.slow_cnt = slow_tick ? '0 : q.slow_cnt + 1'b1;
        if (!tb.driver_en)
        begin
            // a stopped driver restarts from a clean frame
            d.frame_cnt = '0;
        end
        else if (src_tick)
        begin
            if (q.frame_cnt + 1'b1 >= frame_ticks(tb.clk_sel, tb.mux_sel, tb.frame_div))
            begin
                d.frame_cnt = '0;
                d.frame_start = 1'b1; // see [RULE13]
            end
            else
            begin
                d.frame_cnt = q.frame_cnt + 1'b1;
            end
        end
        // blink runs from the 128 Hz base whatever the frame source
        if (!tb.blink_hw_en)
        begin
            d.blink_cnt = '0;
            d.blink_vis = 1'b1;
        end
        else if (slow_tick)
        begin
            if (q.blink_cnt + 1'b1 >= tb.blink_half)
            begin
                d.blink_cnt = '0;
                d.blink_vis = !q.blink_vis; // see [RULE18]
            end
            else
            begin
                d.blink_cnt = q.blink_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            q <= '{blink_vis: 1'b1, default: '0};
        else
            q <= d;
    end

    assign tb.frame_start = q.frame_start;
    assign tb.blink_visible = q.blink_vis;

endmodule : lcd_frame_timebase

//--- verilog/lcd_blink_refresh_control.sv
// Summary of operation
// [RULE1] ladder bit 6 selects external resistor ladder
// [RULE2] software writes ladder reserved bits as zero
// [RULE3] inversion bit inverts every other frame
// [RULE4] software keeps refresh reserved bits cleared
// [RULE5] done flag set after update, new frame
// [RULE6] hold bit stops fetching display data
// [RULE7] fetching resumes at next frame after hold
// [RULE8] only software sets and clears hold
// [RULE9] blink codes 00 off, 01 on, software
// [RULE10] blink code 10 blinks at 2 Hz
// [RULE11] blink code 11 uses rate field
// [RULE12] rate field gives 1, 1/2, 1/3, 1/4 Hz
// [RULE13] frame divider field sets frame rate
// [RULE14] driver runs only while enable set
// [RULE15] blink modes act only while blink enabled
// [RULE16] 128 Hz source uses slower frame table
// [RULE17] done flag sticky until software clears it
// [RULE18] hardware blink uses equal on, off halves
// [RULE19] all fields reset to zero
module lcd_blink_refresh_control
    import lcd_timing_pkg::*;
#(
    parameter int FAST_DIV = CLK_HZ / FAST_SRC_HZ,
    parameter int SLOW_DIV = CLK_HZ / SLOW_SRC_HZ
)(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // special function register access
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    // panel drive controls
    output logic o_driver_on,
    output logic o_ext_ladder_sel,
    output logic o_frame_start,
    output logic o_frame_invert,
    output logic o_fetch_en,
    output logic o_segments_visible
);
    typedef struct packed {
        logic [7:0] main_cfg;
        logic [7:0] timing_cfg;
        logic ext_ladder_sel;
        logic frame_invert_en;
        logic update_done_flag;
        logic hold;
        logic pending;
        logic fetch_en;
        logic frame_start;
        logic invert_phase;
        logic visible;
        logic [7:0] rdata;
    } ctrl_state_t;

    ctrl_state_t q, d;
    lcd_timing_if tif ();

    logic [1:0] blink_source_sel;
    logic [1:0] blink_rate_sel;
    logic flash_mode_en;

    assign blink_source_sel = q.timing_cfg[TIMING_SRC_LSB +: 2];
    assign blink_rate_sel = q.timing_cfg[TIMING_RATE_LSB +: 2];
    assign flash_mode_en = q.main_cfg[MAIN_FLASH_EN_BIT];

    // configuration handed to the timebase
    assign tif.driver_en = q.main_cfg[MAIN_DRV_EN_BIT]; // see [RULE14]
    assign tif.clk_sel = q.main_cfg[MAIN_CLK_SEL_BIT]; // see [RULE16]
    assign tif.mux_sel = q.main_cfg[MAIN_MUX_LSB +: 2];
    assign tif.frame_div = q.timing_cfg[TIMING_FD_LSB +: 4]; // see [RULE13]
    assign tif.blink_hw_en = flash_mode_en && blink_source_sel[1]; // see [RULE15]
    // rate n gives half period of (n + 1) / 2 seconds; fixed mode gives a quarter second
    assign tif.blink_half = (blink_source_sel == BLINK_FIXED) ? BLINK_HALF_2HZ // see [RULE10]
                          : TICK_W'(BLINK_HALF_1HZ * (blink_rate_sel + 1'b1)); // see [RULE12]

    lcd_frame_timebase #(
        .FAST_DIV(FAST_DIV),
        .SLOW_DIV(SLOW_DIV)
    ) u_timebase (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .tb(tif.timebase)
    );

    // register writes, hold handshake, blink and inversion
    always_comb
    begin
        logic wr_ladder;
        logic wr_refresh;
        logic frame_evt;
        wr_ladder = i_sfr_wr && (i_sfr_addr == ADDR_LADDER_CFG);
        wr_refresh = i_sfr_wr && (i_sfr_addr == ADDR_REFRESH_CTRL);
        // a pulse already in flight is dropped when the driver goes off
        frame_evt = tif.frame_start && ((i_sfr_wr && (i_sfr_addr == ADDR_MAIN_CFG))
                    ? i_sfr_wdata[MAIN_DRV_EN_BIT] : tif.driver_en); // see [RULE14]
        d = q;
        d.frame_start = frame_evt;
        if (i_sfr_wr && (i_sfr_addr == ADDR_MAIN_CFG))
            d.main_cfg = i_sfr_wdata;
        if (i_sfr_wr && (i_sfr_addr == ADDR_TIMING_CFG))
            d.timing_cfg = i_sfr_wdata;
        // reserved ladder bits are not stored, software keeps them zero
        if (wr_ladder)
            d.ext_ladder_sel = i_sfr_wdata[LADDER_SEL_BIT]; // see [RULE1] [RULE2]
        if (wr_refresh)
        begin
            // reserved refresh bits are dropped, software keeps them clear
            d.frame_invert_en = i_sfr_wdata[REFRESH_INV_BIT]; // see [RULE3] [RULE4]
            d.hold = i_sfr_wdata[REFRESH_HOLD_BIT]; // see [RULE8]
            // writing one to the done flag has no effect
            if (!i_sfr_wdata[REFRESH_DONE_BIT])
                d.update_done_flag = 1'b0; // see [RULE17]
        end
        // releasing hold marks fresh data waiting for a frame
        if (q.hold && !d.hold)
            d.pending = 1'b1;
        if (q.hold)
        begin
            d.fetch_en = 1'b0; // see [RULE6]
        end
        else if (frame_evt)
        begin
            d.fetch_en = 1'b1; // see [RULE7]
            if (q.pending || (q.hold && !d.hold))
            begin
                d.pending = 1'b0;
                // set wins over a clear in the same cycle
                d.update_done_flag = 1'b1; // see [RULE5] [RULE17]
            end
        end
        // alternate polarity per frame only while inversion is enabled
        if (!q.frame_invert_en || !tif.driver_en)
            d.invert_phase = 1'b0;
        else if (frame_evt)
            d.invert_phase = !q.invert_phase; // see [RULE3]
        // segment visibility under blink control
        if (!flash_mode_en)
            d.visible = 1'b1; // see [RULE15]
        else
        begin
            unique case (blink_source_sel)
                BLINK_SW_OFF: d.visible = 1'b0; // see [RULE9]
                BLINK_SW_ON: d.visible = 1'b1; // see [RULE9]
                BLINK_FIXED, BLINK_RATE: d.visible = tif.blink_visible; // see [RULE10] [RULE11]
            endcase
        end
        // read data follows the address one cycle later
        unique case (i_sfr_addr)
            ADDR_MAIN_CFG: d.rdata = q.main_cfg;
            ADDR_TIMING_CFG: d.rdata = q.timing_cfg;
            ADDR_LADDER_CFG:
            begin
                d.rdata = REG_RESET;
                d.rdata[LADDER_SEL_BIT] = q.ext_ladder_sel;
            end
            ADDR_REFRESH_CTRL:
            begin
                d.rdata = REG_RESET;
                d.rdata[REFRESH_INV_BIT] = q.frame_invert_en;
                d.rdata[REFRESH_DONE_BIT] = q.update_done_flag;
                d.rdata[REFRESH_HOLD_BIT] = q.hold;
            end
            default: d.rdata = READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            q <= '{visible: 1'b1, default: '0}; // see [RULE19]
        else
            q <= d;
    end

    // outputs straight from the state flops
    assign o_sfr_rdata = q.rdata;
    assign o_driver_on = q.main_cfg[MAIN_DRV_EN_BIT]; // see [RULE14]
    assign o_ext_ladder_sel = q.ext_ladder_sel;
    assign o_frame_start = q.frame_start;
    assign o_frame_invert = q.invert_phase;
    assign o_fetch_en = q.fetch_en;
    assign o_segments_visible = q.visible;

endmodule : lcd_blink_refresh_control

//--- dv/lcd_brc_asserts.sv
module lcd_brc_asserts
    import lcd_timing_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // register access
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    // panel drive controls
    input wire logic o_driver_on,
    input wire logic o_ext_ladder_sel,
    input wire logic o_frame_start,
    input wire logic o_frame_invert,
    input wire logic o_fetch_en,
    input wire logic o_segments_visible
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);

    // a write strobe aimed at one register
    sequence s_wr(logic [7:0] a);
        i_sfr_wr && i_sfr_addr == a;
    endsequence

    a_frame_one_cycle: assert property (o_frame_start |=> !o_frame_start)
        else $error("frame pulse too long");
    a_no_frame_off: assert property (!o_driver_on |-> !o_frame_start)
        else $error("frame while driver off");
    // one cycle of slack for the phase to clear after switch-off
    a_invert_idle_off: assert property (!o_driver_on [*2] |-> !o_frame_invert)
        else $error("inversion while driver off");
    a_invert_at_frame: assert property ($rose(o_frame_invert) |-> o_frame_start)
        else $error("inversion away from frame start");
    a_fetch_at_frame: assert property ($rose(o_fetch_en) |-> o_frame_start)
        else $error("fetch resumed away from frame start");
    a_hold_stops_fetch: assert property (
        s_wr(ADDR_REFRESH_CTRL) ##0 i_sfr_wdata[REFRESH_HOLD_BIT] |-> ##2 !o_fetch_en)
        else $error("fetch still on under hold");
    a_ladder_follows: assert property (
        s_wr(ADDR_LADDER_CFG) |=> o_ext_ladder_sel == $past(i_sfr_wdata[LADDER_SEL_BIT]))
        else $error("ladder select not written");
    a_driver_follows: assert property (
        s_wr(ADDR_MAIN_CFG) |=> o_driver_on == $past(i_sfr_wdata[MAIN_DRV_EN_BIT]))
        else $error("driver enable not written");
    a_ladder_readback: assert property (
        s_wr(ADDR_LADDER_CFG) ##1 i_sfr_addr == ADDR_LADDER_CFG
        |=> o_sfr_rdata == {1'b0, $past(i_sfr_wdata[LADDER_SEL_BIT], 2), 6'h00})
        else $error("ladder readback wrong");
endmodule : lcd_brc_asserts

bind lcd_blink_refresh_control lcd_brc_asserts lcd_brc_asserts_i (.*);

//--- dv/lcd_glass_model.sv
module lcd_glass_model
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // drive seen from the block
    input wire logic i_frame_start,
    input wire logic i_frame_invert,
    // frame tallies
    output int o_frames,
    output int o_inverted
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen_q;

    // phase read one cycle after the pulse, once the toggle has landed
    always @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            seen_q <= 1'b0;
            o_frames <= 0;
            o_inverted <= 0;
        end
        else
        begin
            seen_q <= i_frame_start;
            if (seen_q)
            begin
                o_frames <= o_frames + 1;
                o_inverted <= o_inverted + int'(i_frame_invert);
            end
        end
    end
endmodule : lcd_glass_model

//--- dv/lcd_blink_refresh_control_tb.sv
module lcd_blink_refresh_control_tb;
    import lcd_timing_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // short prescalers keep frames under a hundred cycles and blink periods to 2048 cycles at most
    localparam int FD = 2;
    localparam int SD = 4;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr_en = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic drv, ladder, fs, inv, fetch, vis;
    int frames, inverted;
    int failures = 0;
    int n_tests = 0;
    logic [15:0] n;

    lcd_blink_refresh_control #(.FAST_DIV(FD), .SLOW_DIV(SD)) lcd_blink_refresh_control_i (
        .i_sys_clk(clk), .i_resetn(resetn), .i_sfr_addr(addr), .i_sfr_wr(wr_en),
        .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_driver_on(drv),
        .o_ext_ladder_sel(ladder), .o_frame_start(fs), .o_frame_invert(inv),
        .o_fetch_en(fetch), .o_segments_visible(vis));
    lcd_glass_model lcd_glass_model_i (
        .i_sys_clk(clk), .i_resetn(resetn), .i_frame_start(fs), .i_frame_invert(inv),
        .o_frames(frames), .o_inverted(inverted));

    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // one-cycle write strobe, inputs move on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wr_en = 1'b1;
        wdata = d;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        chk("rdata", 16'(rdata), 16'(e));
    endtask : rc

    // gap between two successive frame pulses or visibility changes
    task automatic span(input bit v_sel, output logic [15:0] g);
        logic v;
        for (int e = 0; e < 2; e++)
        begin
            g = 0;
            v = vis;
            do
            begin
                @(negedge clk);
                g++;
            end while (!(v_sel ? vis !== v : fs === 1'b1) && g < 5000);
        end
    endtask : span

    // tallies over exactly four frames, counted after the model settles
    task automatic frames4(output int df, output int di);
        int f0, i0;
        span(1'b0, n);
        repeat (2) @(negedge clk);
        f0 = frames;
        i0 = inverted;
        span(1'b0, n);
        span(1'b0, n);
        repeat (2) @(negedge clk);
        df = frames - f0;
        di = inverted - i0;
    endtask : frames4

    task automatic t_reset();
        chk("outs", 16'({drv, ladder, fs, inv, fetch, vis}), 16'h01);
        rc(ADDR_TIMING_CFG, REG_RESET);
        rc(ADDR_LADDER_CFG, REG_RESET);
        rc(ADDR_REFRESH_CTRL, REG_RESET);
        rc(8'h97, READ_UNMAPPED);
    endtask : t_reset

    task automatic t_ladder();
        wr(ADDR_LADDER_CFG, 8'hff);
        chk("ladder", 16'(ladder), 16'h1);
        rc(ADDR_LADDER_CFG, 8'h40);
        wr(ADDR_LADDER_CFG, 8'h00);
        chk("ladder", 16'(ladder), 16'h0);
    endtask : t_ladder

    // driver off between setups so the frame counter restarts clean
    task automatic t_frames();
        logic [7:0] tm[5] = '{8'h01, 8'h01, 8'h00, 8'h0f, 8'h02};
        logic [7:0] mc[5] = '{8'h83, 8'h82, 8'h8b, 8'h8b, 8'h89};
        logic [15:0] ex[5] = '{16'(16 * FD), 16'(12 * FD), 16'(8 * SD), 16'(4 * SD),
                               16'(12 * SD)};
        for (int i = 0; i < 5; i++)
        begin
            wr(ADDR_MAIN_CFG, 8'h00);
            wr(ADDR_TIMING_CFG, tm[i]);
            wr(ADDR_MAIN_CFG, mc[i]);
            span(1'b0, n);
            chk("frame", n, ex[i]);
        end
    endtask : t_frames

    task automatic t_invert();
        int df, di;
        wr(ADDR_REFRESH_CTRL, 8'hfc);
        rc(ADDR_REFRESH_CTRL, 8'h40);
        frames4(df, di);
        chk("inverted", 16'(di * 2), 16'(df));
        wr(ADDR_REFRESH_CTRL, 8'h00);
        frames4(df, di);
        chk("inverted", 16'(di), 16'h0);
    endtask : t_invert

    task automatic t_hold();
        wr(ADDR_REFRESH_CTRL, 8'h01);
        repeat (2) @(negedge clk);
        chk("fetch", 16'(fetch), 16'h0);
        span(1'b0, n);
        chk("fetch", 16'(fetch), 16'h0);
        rc(ADDR_REFRESH_CTRL, 8'h01);
        wr(ADDR_REFRESH_CTRL, 8'h00);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (fs !== 1'b1 && n < 200);
        chk("fetch", 16'(fetch), 16'h1);
        rc(ADDR_REFRESH_CTRL, 8'h02);
        span(1'b0, n);
        wr(ADDR_REFRESH_CTRL, 8'h02);
        rc(ADDR_REFRESH_CTRL, 8'h02);
        wr(ADDR_REFRESH_CTRL, 8'h00);
        span(1'b0, n);
        rc(ADDR_REFRESH_CTRL, 8'h00);
    endtask : t_hold

    task automatic t_blink();
        wr(ADDR_MAIN_CFG, 8'hab);
        wr(ADDR_TIMING_CFG, 8'h0f);
        @(negedge clk);
        chk("visible", 16'(vis), 16'h0);
        wr(ADDR_TIMING_CFG, 8'h4f);
        @(negedge clk);
        chk("visible", 16'(vis), 16'h1);
        wr(ADDR_TIMING_CFG, 8'h8f);
        span(1'b1, n);
        chk("half", n, 16'(32 * SD));
        for (int r = 0; r < 4; r++)
        begin
            wr(ADDR_TIMING_CFG, {2'b11, 2'(r), 4'hf});
            span(1'b1, n);
            chk("half", n, 16'(64 * (r + 1) * SD));
        end
        wr(ADDR_TIMING_CFG, 8'h0f);
        wr(ADDR_MAIN_CFG, 8'h8b);
        repeat (2) @(negedge clk);
        chk("visible", 16'(vis), 16'h1);
        wr(ADDR_MAIN_CFG, 8'h00);
        span(1'b0, n);
        chk("frame", n, 16'h1388);
    endtask : t_blink

    task automatic summarize();
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        t_reset();
        t_ladder();
        t_frames();
        t_invert();
        t_hold();
        t_blink();
        summarize();
    end

    // generous over the roughly 20k cycles of the run
    initial
    begin
        #400_000;
        failures++;
        summarize();
    end
endmodule : lcd_blink_refresh_control_tb
